// File: rtl/jpp_pkg.sv
// Constants and types for the scan-port programming block
// Behaviour
// - Port usable only with enable fuse set; disable bit clears after two clocks of reset.
// - Every scan register shifts least significant bit first, in and out.
// - Four-bit instruction register; opcodes 0x6 and 0x7 share one data register, part of the command register.
// - Run-Test/Idle makes internal programming clocks and serves as an idle state.
// - Opcode 0xC selects the one-bit reset chain; the tap controller is not reset.
// - A one in the reset chain holds the device in reset at once.
// - After the chain clears, reset lasts the fuse-selected time-out.
// - Opcode 0x4 selects the 16-bit key register, compared on Update-DR.
// - Programming is enabled only while the key equals 0b1010_0011_0111_0000.
// - Key register clears on reset; the programmer clears it on leaving programming.
// - Opcode 0x5 selects the 15-bit command register; capture loads the previous result.
// - Update-DR applies the command; each Run-Test/Idle cycle makes one execute clock.
// - Opcode 0x6 selects the byte register, the command register's low eight bits.
// - Page-load update copies the byte to a holding register, written into the page buffer.
// - Page-load alternates low, high from low; counter pre-increments before later low bytes.
// - Opcode 0x7 captures flash bytes, low then high, starting low after entry.
// - Page-read post-increments the counter after every high byte, the first included.
`default_nettype none
package jpp_pkg;
  localparam int IR_W = 4;
  localparam int KEY_W = 16;
  localparam int CMD_W = 15;
  localparam int BYTE_W = 8;
  localparam logic [3:0] OP_ENABLE_KEY = 4'h4;
  localparam logic [3:0] OP_COMMAND = 4'h5;
  localparam logic [3:0] OP_PAGE_LOAD = 4'h6;
  localparam logic [3:0] OP_PAGE_READ = 4'h7;
  localparam logic [3:0] OP_RESET_CHAIN = 4'hC;
  localparam logic [3:0] OP_BYPASS = 4'hF;
  localparam logic [3:0] IR_RESET_VAL = 4'hF;
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;
  localparam logic [15:0] ENABLE_KEY = 16'hA370;
  localparam logic [15:0] KEY_RESET_VAL = 16'h0000;
  localparam logic [14:0] CMD_RESET_VAL = 15'h0000;
  localparam logic [1:0] DISABLE_CLEAR_CYC = 2'h2;
  localparam int CLK_NS = 8;
  localparam int RST_TO_FAST_NS = 8000;
  localparam int RST_TO_FAST_CYC = RST_TO_FAST_NS / CLK_NS;
  localparam int RST_TO_SLOW_NS = 65000000;
  localparam int RST_TO_W = 24;
  // Tap states, one-hot
  typedef enum logic [15:0] {
    ST_RESET   = 16'h0001, ST_IDLE    = 16'h0002, ST_DR_SEL  = 16'h0004, ST_DR_CAP  = 16'h0008,
    ST_DR_SH   = 16'h0010, ST_DR_EX1  = 16'h0020, ST_DR_PAUSE = 16'h0040, ST_DR_EX2 = 16'h0080,
    ST_DR_UPD  = 16'h0100, ST_IR_SEL  = 16'h0200, ST_IR_CAP  = 16'h0400, ST_IR_SH   = 16'h0800,
    ST_IR_EX1  = 16'h1000, ST_IR_PAUSE = 16'h2000, ST_IR_EX2 = 16'h4000, ST_IR_UPD  = 16'h8000
  } jpp_tap_t;
endpackage
`default_nettype wire

// File: rtl/jpp_fifo.sv
// Valid/ready FIFO between byte loading and the page buffer
`default_nettype none
module jpp_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("jpp_fifo depth must be a power of two");
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Storage, no reset needed on data
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: rtl/jpp_port.sv
// Scan-port programming logic: tap controller, key, command and page byte registers
`default_nettype none
module jpp_port #(
  parameter int FIFO_DEPTH = 8,
  parameter int RST_TO_SLOW_CYC = jpp_pkg::RST_TO_SLOW_NS / jpp_pkg::CLK_NS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic ext_reset_n,
  input wire logic scan_port_enable_fuse,
  input wire logic [1:0] clock_option_fuses,
  input wire logic disable_set_req,
  input wire logic disable_clr_req,
  output logic scan_port_disable_bit,
  output logic device_reset,
  output logic prog_mode,
  output logic [14:0] flash_cmd,
  output logic flash_exec,
  input wire logic [14:0] flash_result,
  input wire logic [15:0] flash_word,
  output logic pc_post_inc,
  output logic page_wr_valid,
  input wire logic page_wr_ready,
  output logic [7:0] page_wr_data,
  output logic page_wr_high,
  output logic page_wr_pre_inc
);
  if (RST_TO_SLOW_CYC < 1 || RST_TO_SLOW_CYC >= (1 << jpp_pkg::RST_TO_W)) $error("bad time-out");
  localparam logic [23:0] TO_FAST = 24'(jpp_pkg::RST_TO_FAST_CYC);
  localparam logic [23:0] TO_SLOW = 24'(RST_TO_SLOW_CYC);
  logic [1:0] tck_sync, tms_sync, tdi_sync, rstn_sync;
  logic tck_d, tck_rise, tck_fall, port_en;
  logic [1:0] low_cnt;
  jpp_pkg::jpp_tap_t state, next_state;
  logic [3:0] ir, ir_shift;
  logic bypass_bit, reset_chain;
  logic [15:0] key_shift;
  logic [14:0] cmd_shift;
  logic load_high, load_first, read_high;
  logic [7:0] hold_byte;
  logic hold_pending, hold_high, hold_pre_inc, fifo_in_ready;
  logic [23:0] to_cnt;
  logic in_reset, dr_upd, dr_cap, dr_sh;
  // Pin synchronisers; only the second stage is read
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tck_sync <= 2'h0;
      tms_sync <= 2'h3;
      tdi_sync <= 2'h0;
      rstn_sync <= 2'h3;
      tck_d <= 1'b0;
    end
    else
    begin
      tck_sync <= {tck_sync[0], tck};
      tms_sync <= {tms_sync[0], tms};
      tdi_sync <= {tdi_sync[0], tdi};
      rstn_sync <= {rstn_sync[0], ext_reset_n};
      tck_d <= tck_sync[1];
    end
  end
  assign tck_rise = tck_sync[1] && !tck_d;
  assign tck_fall = !tck_sync[1] && tck_d;
  // Disable bit: software sets and clears it; pin reset held two clocks clears it and keeps it clear
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      scan_port_disable_bit <= 1'b0;
      low_cnt <= 2'h0;
    end
    else
    begin
      low_cnt <= rstn_sync[1] ? 2'h0 : (low_cnt == jpp_pkg::DISABLE_CLEAR_CYC ? low_cnt : low_cnt + 2'h1);
      if (!rstn_sync[1] && low_cnt >= jpp_pkg::DISABLE_CLEAR_CYC - 2'h1)
        scan_port_disable_bit <= 1'b0;
      else if (disable_set_req)
        scan_port_disable_bit <= 1'b1;
      else if (disable_clr_req)
        scan_port_disable_bit <= 1'b0;
    end
  end
  assign port_en = scan_port_enable_fuse && !scan_port_disable_bit;
  // Standard tap transitions on mode select
  always_comb
  begin
    unique case (state)
      jpp_pkg::ST_RESET: next_state = tms_sync[1] ? jpp_pkg::ST_RESET : jpp_pkg::ST_IDLE;
      jpp_pkg::ST_IDLE: next_state = tms_sync[1] ? jpp_pkg::ST_DR_SEL : jpp_pkg::ST_IDLE;
      jpp_pkg::ST_DR_SEL: next_state = tms_sync[1] ? jpp_pkg::ST_IR_SEL : jpp_pkg::ST_DR_CAP;
      jpp_pkg::ST_DR_CAP: next_state = tms_sync[1] ? jpp_pkg::ST_DR_EX1 : jpp_pkg::ST_DR_SH;
      jpp_pkg::ST_DR_SH: next_state = tms_sync[1] ? jpp_pkg::ST_DR_EX1 : jpp_pkg::ST_DR_SH;
      jpp_pkg::ST_DR_EX1: next_state = tms_sync[1] ? jpp_pkg::ST_DR_UPD : jpp_pkg::ST_DR_PAUSE;
      jpp_pkg::ST_DR_PAUSE: next_state = tms_sync[1] ? jpp_pkg::ST_DR_EX2 : jpp_pkg::ST_DR_PAUSE;
      jpp_pkg::ST_DR_EX2: next_state = tms_sync[1] ? jpp_pkg::ST_DR_UPD : jpp_pkg::ST_DR_SH;
      jpp_pkg::ST_DR_UPD: next_state = tms_sync[1] ? jpp_pkg::ST_DR_SEL : jpp_pkg::ST_IDLE;
      jpp_pkg::ST_IR_SEL: next_state = tms_sync[1] ? jpp_pkg::ST_RESET : jpp_pkg::ST_IR_CAP;
      jpp_pkg::ST_IR_CAP: next_state = tms_sync[1] ? jpp_pkg::ST_IR_EX1 : jpp_pkg::ST_IR_SH;
      jpp_pkg::ST_IR_SH: next_state = tms_sync[1] ? jpp_pkg::ST_IR_EX1 : jpp_pkg::ST_IR_SH;
      jpp_pkg::ST_IR_EX1: next_state = tms_sync[1] ? jpp_pkg::ST_IR_UPD : jpp_pkg::ST_IR_PAUSE;
      jpp_pkg::ST_IR_PAUSE: next_state = tms_sync[1] ? jpp_pkg::ST_IR_EX2 : jpp_pkg::ST_IR_PAUSE;
      jpp_pkg::ST_IR_EX2: next_state = tms_sync[1] ? jpp_pkg::ST_IR_UPD : jpp_pkg::ST_IR_SH;
      jpp_pkg::ST_IR_UPD: next_state = tms_sync[1] ? jpp_pkg::ST_DR_SEL : jpp_pkg::ST_IDLE;
      default: next_state = jpp_pkg::ST_RESET;
    endcase
  end
  // A disabled port holds the controller in its reset state
  always_ff @(posedge sys_clk)
  begin
    if (rst || !port_en)
      state <= jpp_pkg::ST_RESET;
    else if (tck_rise)
      state <= next_state;
  end

  assign dr_upd = tck_rise && state == jpp_pkg::ST_DR_UPD;
  assign dr_cap = tck_rise && state == jpp_pkg::ST_DR_CAP;
  assign dr_sh = tck_rise && state == jpp_pkg::ST_DR_SH;

  // Instruction register, shifted low bit first
  always_ff @(posedge sys_clk)
  begin
    if (rst || state == jpp_pkg::ST_RESET)
    begin
      ir <= jpp_pkg::IR_RESET_VAL;
      ir_shift <= jpp_pkg::IR_RESET_VAL;
    end
    else if (tck_rise)
    begin
      if (state == jpp_pkg::ST_IR_CAP)
        ir_shift <= jpp_pkg::IR_CAPTURE_VAL;
      else if (state == jpp_pkg::ST_IR_SH)
        ir_shift <= {tdi_sync[1], ir_shift[3:1]};
      else if (state == jpp_pkg::ST_IR_UPD)
        ir <= ir_shift;
    end
  end

  // Reset chain and bypass; the chain bit is the reset itself, not a latched copy
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reset_chain <= 1'b0;
      bypass_bit <= 1'b0;
    end
    else if (dr_sh && ir == jpp_pkg::OP_RESET_CHAIN)
      reset_chain <= tdi_sync[1];
    else if (dr_cap)
      bypass_bit <= 1'b0;
    else if (dr_sh)
      bypass_bit <= tdi_sync[1];
  end

  // Device reset: chain or pin, then a fuse-selected time-out
  assign in_reset = reset_chain || !rstn_sync[1];
  always_ff @(posedge sys_clk)
  begin
    if (rst || in_reset)
    begin
      unique case (clock_option_fuses)
        2'h0: to_cnt <= 24'h000001;
        2'h1: to_cnt <= TO_FAST;
        default: to_cnt <= TO_SLOW;
      endcase
    end
    else if (to_cnt != 24'h000000)
      to_cnt <= to_cnt - 24'h000001;
  end
  assign device_reset = in_reset || to_cnt != 24'h000000;

  // Key register and programming mode, which only a matching update grants
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      key_shift <= jpp_pkg::KEY_RESET_VAL;
      prog_mode <= 1'b0;
    end
    else if (ir == jpp_pkg::OP_ENABLE_KEY)
    begin
      if (dr_sh)
        key_shift <= {tdi_sync[1], key_shift[15:1]};
      else if (dr_upd)
        prog_mode <= key_shift == jpp_pkg::ENABLE_KEY;
    end
  end

  // Command register; its low byte doubles as the page byte register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cmd_shift <= jpp_pkg::CMD_RESET_VAL;
      read_high <= 1'b0;
      pc_post_inc <= 1'b0;
    end
    else
    begin
      pc_post_inc <= 1'b0;
      if (tck_rise && state == jpp_pkg::ST_IR_UPD)
        read_high <= 1'b0;
      if (ir == jpp_pkg::OP_COMMAND)
      begin
        if (dr_cap)
          cmd_shift <= flash_result;
        else if (dr_sh)
          cmd_shift <= {tdi_sync[1], cmd_shift[14:1]};
      end
      else if (ir == jpp_pkg::OP_PAGE_LOAD || ir == jpp_pkg::OP_PAGE_READ)
      begin
        if (dr_cap && ir == jpp_pkg::OP_PAGE_READ && prog_mode)
        begin
          cmd_shift[7:0] <= read_high ? flash_word[15:8] : flash_word[7:0];
          read_high <= !read_high;
          pc_post_inc <= read_high;
        end
        else if (dr_sh)
          cmd_shift[7:0] <= {tdi_sync[1], cmd_shift[7:1]};
      end
    end
  end

  // Apply command on update, one execute clock per idle cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      flash_cmd <= jpp_pkg::CMD_RESET_VAL;
      flash_exec <= 1'b0;
    end
    else
    begin
      flash_exec <= tck_rise && state == jpp_pkg::ST_IDLE && ir == jpp_pkg::OP_COMMAND && prog_mode;
      if (dr_upd && ir == jpp_pkg::OP_COMMAND && prog_mode)
        flash_cmd <= cmd_shift;
    end
  end

  // Page-load holding register; a full FIFO holds the byte until room appears
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hold_byte <= 8'h00;
      hold_pending <= 1'b0;
      hold_high <= 1'b0;
      hold_pre_inc <= 1'b0;
      load_high <= 1'b0;
      load_first <= 1'b1;
    end
    else
    begin
      if (hold_pending && fifo_in_ready)
        hold_pending <= 1'b0;
      if (tck_rise && state == jpp_pkg::ST_IR_UPD)
      begin
        load_high <= 1'b0;
        load_first <= 1'b1;
      end
      else if (dr_upd && ir == jpp_pkg::OP_PAGE_LOAD && prog_mode)
      begin
        hold_byte <= cmd_shift[7:0];
        hold_pending <= 1'b1;
        hold_high <= load_high;
        hold_pre_inc <= !load_high && !load_first;
        load_high <= !load_high;
        load_first <= 1'b0;
      end
    end
  end

  jpp_fifo #(.W(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(hold_pending),
    .in_ready(fifo_in_ready),
    .in_data({hold_pre_inc, hold_high, hold_byte}),
    .out_valid(page_wr_valid),
    .out_ready(page_wr_ready),
    .out_data({page_wr_pre_inc, page_wr_high, page_wr_data})
  );

  // Data out changes on the falling test clock, low bit first
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (!port_en)
      tdo_oe <= 1'b0;
    else if (tck_fall)
    begin
      tdo_oe <= state == jpp_pkg::ST_IR_SH || state == jpp_pkg::ST_DR_SH;
      if (state == jpp_pkg::ST_IR_SH)
        tdo <= ir_shift[0];
      else
        unique case (ir)
          jpp_pkg::OP_RESET_CHAIN: tdo <= reset_chain;
          jpp_pkg::OP_ENABLE_KEY: tdo <= key_shift[0];
          jpp_pkg::OP_COMMAND, jpp_pkg::OP_PAGE_LOAD, jpp_pkg::OP_PAGE_READ: tdo <= cmd_shift[0];
          default: tdo <= bypass_bit;
        endcase
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence seq_key_update;
    dr_upd && ir == jpp_pkg::OP_ENABLE_KEY;
  endsequence
  chk_port_gate: assert property (!port_en |=> !tdo_oe) else $error("tdo driven while port disabled");
  chk_disable_clear: assert property (!rstn_sync[1] [*2] |=> !scan_port_disable_bit)
    else $error("disable bit not cleared");
  chk_chain_reset: assert property (reset_chain |-> device_reset) else $error("chain without reset");
  chk_reset_tail: assert property ($fell(in_reset) |-> device_reset) else $error("no time-out");
  chk_key_match: assert property (seq_key_update ##0 key_shift == jpp_pkg::ENABLE_KEY |=> prog_mode)
    else $error("key match not granted");
  chk_key_miss: assert property (seq_key_update ##0 key_shift != jpp_pkg::ENABLE_KEY |=> !prog_mode)
    else $error("wrong key granted");
  chk_cmd_apply: assert property (dr_upd && ir == jpp_pkg::OP_COMMAND && prog_mode
    |=> flash_cmd == $past(cmd_shift)) else $error("command not applied");
  chk_cmd_locked: assert property (!prog_mode |=> $stable(flash_cmd) && !flash_exec)
    else $error("command acted outside programming");
  chk_read_postinc: assert property (dr_cap && ir == jpp_pkg::OP_PAGE_READ && prog_mode && read_high
    |=> pc_post_inc) else $error("no post-increment");
  chk_load_alt: assert property (dr_upd && ir == jpp_pkg::OP_PAGE_LOAD && prog_mode
    |=> hold_pending && hold_high != load_high) else $error("load order broken");
endmodule
`default_nettype wire

// File: tb/jpp_prog_model.sv
// Programmer model that works the block through the four test pins only
`default_nettype none
module jpp_prog_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  logic junk;

  // Pins start with the test clock still and mode select high
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One 125 ns test clock; tdo is read just before the rise, long after the fall that moved it
  // Half-nanosecond offsets keep every pin change off a system clock edge
  task automatic bit_cyc(input logic m, input logic d, output logic q);
    #0.5;
    tms = m;
    tdi = d;
    #30;
    q = tdo;
    tck = 1'b1;
    #62;
    tck = 1'b0;
    #32.5;
  endtask

  // Outside a shift tdi flips every cycle, so a stale bit never passes for data
  task automatic step(input logic m);
    bit_cyc(m, ~tdi, junk);
  endtask

  // Parking in Run-Test/Idle clocks the internal execute strobe
  task automatic idle(input int n);
    repeat (n) step(1'b0);
  endtask

  // Idle to Shift-IR or Shift-DR, n bits LSB first, then Update and back to Idle
  task automatic shift(input logic ir, input int n, input logic [15:0] d, output logic [15:0] q);
    q = '0;
    step(1'b1);
    if (ir)
      step(1'b1);
    step(1'b0);
    step(1'b0);
    for (int i = 0; i < n; i++)
      bit_cyc(i == n - 1, d[i], q[i]);
    step(1'b1);
    step(1'b0);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the scan-port programming block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst, tck, tms, tdi, tdo, tdo_oe, ext_reset_n, scan_port_enable_fuse;
  logic disable_set_req, disable_clr_req, scan_port_disable_bit, device_reset, prog_mode;
  logic flash_exec, pc_post_inc, page_wr_valid, page_wr_ready, page_wr_high, page_wr_pre_inc;
  logic [1:0] clock_option_fuses;
  logic [14:0] flash_cmd, flash_result;
  logic [15:0] flash_word;
  logic [7:0] page_wr_data;
  int n_errors = 0, checked = 0, n_exec = 0, n_inc = 0, n_oe = 0;

  // Slow time-out shortened so the fuse setting can be seen in a short run
  jpp_port #(.FIFO_DEPTH(8), .RST_TO_SLOW_CYC(20)) i_dut (.sys_clk, .rst, .tck, .tms, .tdi, .tdo, .tdo_oe,
    .ext_reset_n, .scan_port_enable_fuse, .clock_option_fuses, .disable_set_req, .disable_clr_req,
    .scan_port_disable_bit, .device_reset, .prog_mode, .flash_cmd, .flash_exec, .flash_result, .flash_word,
    .pc_post_inc, .page_wr_valid, .page_wr_ready, .page_wr_data, .page_wr_high, .page_wr_pre_inc);
  jpp_prog_model i_prog (.tck, .tms, .tdi, .tdo);

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Pulse counters; a pulse standing one cycle is seen at exactly one edge
  always @(posedge sys_clk)
  begin
    if (flash_exec === 1'b1)
      n_exec++;
    if (pc_post_inc === 1'b1)
      n_inc++;
    if (tdo_oe === 1'b1)
      n_oe++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic chk_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic ir(input logic [3:0] op);
    logic [15:0] q;
    i_prog.shift(1'b1, 4, {12'h000, op}, q);
  endtask

  task automatic t_reset;
    chk_bit("prog_mode", 1'b0, prog_mode);
    chk_bit("tdo_oe", 1'b0, tdo_oe);
    chk_bit("device_reset", 1'b0, device_reset);
    chk_vec("flash_cmd", 16'h0000, {1'b0, flash_cmd});
    i_prog.idle(1);
  endtask

  // Chain set first, as the programmer must before enabling programming
  task automatic t_chain;
    logic [15:0] q;
    n_oe = 0;
    i_prog.shift(1'b1, 4, {12'h000, jpp_pkg::OP_RESET_CHAIN}, q);
    chk_vec("ir capture", {12'h000, jpp_pkg::IR_CAPTURE_VAL}, q);
    chk_bit("tdo_oe seen", 1'b1, n_oe > 0);
    i_prog.shift(1'b0, 1, 16'h0001, q);
    chk_bit("device_reset", 1'b1, device_reset);
    i_prog.shift(1'b0, 1, 16'h0001, q);
    chk_bit("chain out", 1'b1, q[0]);
  endtask

  // Commands are ignored until the exact key is updated
  task automatic t_key;
    logic [15:0] q;
    ir(jpp_pkg::OP_COMMAND);
    i_prog.shift(1'b0, 15, 16'h1234, q);
    n_exec = 0;
    i_prog.idle(2);
    chk_vec("flash_cmd", 16'h0000, {1'b0, flash_cmd});
    chk_vec("exec count", 16'h0000, n_exec[15:0]);
    ir(jpp_pkg::OP_ENABLE_KEY);
    i_prog.shift(1'b0, 16, 16'hA371, q);
    chk_bit("prog_mode", 1'b0, prog_mode);
    i_prog.shift(1'b0, 16, 16'hA370, q);
    chk_bit("prog_mode", 1'b1, prog_mode);
  endtask

  task automatic t_cmd;
    logic [15:0] q;
    @(posedge sys_clk) flash_result <= 15'h2A5C;
    ir(jpp_pkg::OP_COMMAND);
    i_prog.shift(1'b0, 15, 16'h1234, q);
    chk_vec("command capture", 16'h2A5C, q);
    chk_vec("flash_cmd", 16'h1234, {1'b0, flash_cmd});
    n_exec = 0;
    i_prog.idle(3);
    chk_vec("exec count", 16'h0003, n_exec[15:0]);
  endtask

  // Page buffer stalls while nine bytes load, then drains with the test clock running
  task automatic t_load;
    logic [15:0] q;
    int n;
    n = 0;
    @(posedge sys_clk) page_wr_ready <= 1'b0;
    ir(jpp_pkg::OP_PAGE_LOAD);
    for (int i = 0; i < 9; i++)
    begin
      i_prog.shift(1'b0, 8, 16'h0010 + 16'(i), q);
      if (i == 0)
        chk_vec("byte register", 16'h0034, q);
      if (i == 1)
        chk_vec("stalled head", 16'h0110, {7'h00, page_wr_valid, page_wr_data});
    end
    @(posedge sys_clk) page_wr_ready <= 1'b1;
    fork
      i_prog.idle(24);
      repeat (400)
      begin
        @(negedge sys_clk);
        if (page_wr_valid === 1'b1)
        begin
          chk_vec("page data", 16'h0010 + 16'(n), {8'h00, page_wr_data});
          chk_bit("high byte", n[0], page_wr_high);
          chk_bit("pre increment", n[0] == 1'b0 && n != 0, page_wr_pre_inc);
          n++;
        end
      end
    join
    chk_vec("bytes written", 16'h0009, n[15:0]);
    chk_bit("page_wr_valid", 1'b0, page_wr_valid);
  endtask

  task automatic t_read;
    logic [15:0] q;
    @(posedge sys_clk) flash_word <= 16'hBEEF;
    ir(jpp_pkg::OP_PAGE_READ);
    n_inc = 0;
    for (int i = 0; i < 3; i++)
    begin
      // A new word before the last capture shows the byte is taken at capture time
      if (i == 2)
        @(posedge sys_clk) flash_word <= 16'hC35A;
      i_prog.shift(1'b0, 8, 16'h0000, q);
      chk_vec("read byte", i == 2 ? 16'h005A : (i[0] ? 16'h00BE : 16'h00EF), q);
      chk_vec("post increments", 16'((i + 1) / 2), n_inc[15:0]);
    end
  endtask

  // Key cleared on leaving, then the chain released under the 1000-cycle time-out
  task automatic t_release;
    logic [15:0] q;
    int cnt;
    ir(jpp_pkg::OP_ENABLE_KEY);
    i_prog.shift(1'b0, 16, 16'h0000, q);
    chk_bit("prog_mode", 1'b0, prog_mode);
    @(posedge sys_clk) clock_option_fuses <= 2'h1;
    ir(jpp_pkg::OP_RESET_CHAIN);
    i_prog.shift(1'b0, 1, 16'h0000, q);
    chk_bit("device_reset", 1'b1, device_reset);
    cnt = 0;
    while (device_reset !== 1'b0 && cnt < 1200)
    begin
      cyc(1);
      cnt++;
    end
    chk_bit("time-out length", 1'b1, cnt > 900 && cnt < 1000);
  endtask

  task automatic t_disable;
    @(posedge sys_clk) disable_set_req <= 1'b1;
    @(posedge sys_clk) disable_set_req <= 1'b0;
    cyc(2);
    chk_bit("disable bit", 1'b1, scan_port_disable_bit);
    n_oe = 0;
    ir(jpp_pkg::OP_BYPASS);
    chk_vec("tdo_oe cycles", 16'h0000, n_oe[15:0]);
    @(posedge sys_clk) disable_clr_req <= 1'b1;
    @(posedge sys_clk) disable_clr_req <= 1'b0;
    cyc(2);
    chk_bit("disable bit", 1'b0, scan_port_disable_bit);
    // Set again, then let the pin reset clear it under the slow time-out setting
    @(posedge sys_clk) disable_set_req <= 1'b1;
    @(posedge sys_clk) disable_set_req <= 1'b0;
    ext_reset_n <= 1'b0;
    clock_option_fuses <= 2'h2;
    cyc(6);
    chk_bit("disable bit", 1'b0, scan_port_disable_bit);
    chk_bit("device_reset", 1'b1, device_reset);
    @(posedge sys_clk) ext_reset_n <= 1'b1;
    cyc(12);
    @(negedge sys_clk);
    chk_bit("slow time-out running", 1'b1, device_reset);
    cyc(16);
    @(negedge sys_clk);
    chk_bit("slow time-out over", 1'b0, device_reset);
    @(posedge sys_clk) scan_port_enable_fuse <= 1'b0;
    n_oe = 0;
    ir(jpp_pkg::OP_BYPASS);
    chk_vec("tdo_oe cycles", 16'h0000, n_oe[15:0]);
  endtask

  // Main sequence; reset held for four clocks
  initial
  begin
    rst = 1'b1;
    ext_reset_n = 1'b1;
    scan_port_enable_fuse = 1'b1;
    clock_option_fuses = 2'h0;
    disable_set_req = 1'b0;
    disable_clr_req = 1'b0;
    flash_result = 15'h0000;
    flash_word = 16'h0000;
    page_wr_ready = 1'b1;
    cyc(4);
    rst <= 1'b0;
    cyc(4);
    t_reset;
    t_chain;
    t_key;
    t_cmd;
    t_load;
    t_read;
    t_release;
    t_disable;
    stop_test;
  end

  // Watchdog well beyond the roughly 60 us that the sequence needs
  initial
  begin
    #300000;
    n_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
